//--- hw/pwm_timer.sv
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
// Contract
// - Two free-running glitch-free 8-bit PWM channels.
// - Pair never high together; one-tick dead time.
// - Fast mode: rise tick+fast cycle, fall fast cycle; the mode 10 true output rises after one fast cycle only.
// - Sync mode: rise tick+clock, fall one clock; the mode 10 true output rises after one clock only.
// - Compare match acts per mode; 00 disconnects.
// - Counter counts zero to period, then restarts.
// - Period match sets overflow flag after delay.
// - Mode 01 drives complementary delayed pair.
// - Mode 10 clears on match, sets at one.
// - Mode 11 sets after match, clears at one.
// - Compare writes held until period match while enabled.
// - Compare reads return most recent written value.
// - Compare zero or period gives static levels.
// - Flags request interrupt with own and global enable.
// - PWM period is tick period times period+1.
// - Select codes 1..5 divide by 1..16.
// - Enable bit selects PWM; counter clears after match.
// - Fast enable picks PLL clock, else system clock.
// - Select zero stops the counter.
module pwm_timer #(
    parameter int DIV_W = 14
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_fast_pll_clock,
    input  wire logic        i_pll_locked,
    input  wire logic        i_global_irq_enable,
    output logic             o_pll_enable,
    output logic             o_irq_request,
    output logic             o_pwm_a_out,
    output logic             o_pwm_a_inv,
    output logic             o_pwm_a_drive,
    output logic             o_pwm_a_inv_drive,
    output logic             o_pwm_b_out,
    output logic             o_pwm_b_inv,
    output logic             o_pwm_b_drive,
    output logic             o_pwm_b_inv_drive
);
    import pwm_pkg::*;

    typedef struct packed {
        bus_state_t  bus;
        logic [31:0] rdata;
        mode_t       mode_a;
        mode_t       mode_b;
        logic        en_a;
        logic        en_b;
        logic [3:0]  select;
        logic        psr;
        logic [7:0]  cnt;
        logic [7:0]  cmp_a;
        logic [7:0]  cmp_b;
        logic [7:0]  hold_a;
        logic [7:0]  hold_b;
        logic [7:0]  period;
        logic        fast_en;
        logic        pll_en;
        logic        fclk;
        logic [2:0]  evt;
        logic [2:0]  flags;
        logic [2:0]  irq_en;
        logic        irq;
    } state_t;

    localparam state_t STATE_RESET = '{
        bus: BUS_IDLE, rdata: 32'h0, mode_a: MODE_OFF, mode_b: MODE_OFF,
        en_a: 1'b0, en_b: 1'b0, select: SELECT_RESET, psr: 1'b0, cnt: 8'h00,
        cmp_a: COMPARE_RESET, cmp_b: COMPARE_RESET, hold_a: COMPARE_RESET,
        hold_b: COMPARE_RESET, period: PERIOD_RESET, fast_en: 1'b0, pll_en: 1'b0,
        fclk: 1'b0, evt: 3'h0, flags: 3'h0, irq_en: 3'h0, irq: 1'b0
    };

    state_t q;
    state_t d;
    logic       base_tick;
    logic       tick;
    logic       wrap;
    logic       wr;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic [2:0] clr;

    // Fast mode steps on each rising edge of the PLL clock, seen as a synchronous input.
    // The PLL clock must run well below the system clock for every edge to be seen.
    assign base_tick = q.fast_en ? (i_fast_pll_clock && !q.fclk) : 1'b1;
    assign wrap = q.cnt == q.period;
    assign wr = i_avs_write && i_avs_byteenable[0];
    assign wbyte = i_avs_writedata[7:0];
    assign clr = (wr && i_avs_address == ADDR_FLAGS) ? wbyte[2:0] : 3'h0;

    pwm_prescaler #(
        .DIV_W(DIV_W)
    ) u_prescaler (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_base_tick(base_tick),
        .i_select   (q.select),
        .i_clear    (q.psr),
        .o_tick     (tick)
    );

    // Read mux; unmapped words read as zero.
    always_comb begin
        rd_byte = 8'h00;
        case (i_avs_address)
            ADDR_CONTROL_A: rd_byte = {q.mode_a, q.mode_b, 2'h0, q.en_a, q.en_b};
            ADDR_CONTROL_B: rd_byte = {4'h0, q.select};
            ADDR_COUNTER:   rd_byte = q.cnt;
            ADDR_COMPARE_A: rd_byte = q.hold_a;
            ADDR_COMPARE_B: rd_byte = q.hold_b;
            ADDR_PERIOD:    rd_byte = q.period;
            ADDR_PLL:       rd_byte = {5'h0, q.fast_en, q.pll_en, i_pll_locked};
            ADDR_FLAGS:     rd_byte = {5'h0, q.flags};
            ADDR_IRQ_EN:    rd_byte = {5'h0, q.irq_en};
            default:        rd_byte = 8'h00;
        endcase
    end

    // Reads take one wait cycle so the answer always comes from a flip-flop.
    assign o_avs_waitrequest = (q.bus == BUS_IDLE) && i_avs_read;

    // Next-state logic for counter, compare buffering, flags and registers.
    always_comb begin
        d = q;
        d.fclk = i_fast_pll_clock;
        d.psr = 1'b0;
        unique case (q.bus)
            BUS_IDLE: begin
                if (i_avs_read) begin
                    d.rdata = {24'h0, rd_byte};
                    d.bus = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                d.bus = BUS_IDLE;
            end
        endcase
        if (tick) begin
            if (wrap) begin
                d.cnt = 8'h00;
                if (q.en_a) begin
                    d.cmp_a = q.hold_a;
                end
                if (q.en_b) begin
                    d.cmp_b = q.hold_b;
                end
            end else begin
                d.cnt = q.cnt + 8'h01;
            end
        end
        // One stage of delay stands in for the timer-to-bus resynchronizer.
        d.evt[FLAG_OVF] = tick && wrap;
        d.evt[FLAG_CMP_A] = tick && q.cnt == q.cmp_a;
        d.evt[FLAG_CMP_B] = tick && q.cnt == q.cmp_b;
        d.flags = flag_update(q.flags, q.evt, clr);
        d.irq = i_global_irq_enable && |(q.flags & q.irq_en);
        if (!q.pll_en) begin
            d.fast_en = 1'b0;
        end
        if (wr) begin
            unique case (i_avs_address)
                ADDR_CONTROL_A: begin
                    d.mode_a = mode_t'(wbyte[MODE_A_LSB+:2]);
                    d.mode_b = mode_t'(wbyte[MODE_B_LSB+:2]);
                    d.en_a = wbyte[PWM_A_EN_BIT];
                    d.en_b = wbyte[PWM_B_EN_BIT];
                end
                ADDR_CONTROL_B: begin
                    d.select = wbyte[3:0];
                    d.psr = wbyte[PSR_BIT];
                end
                ADDR_COUNTER: begin
                    d.cnt = wbyte;
                end
                ADDR_COMPARE_A: begin
                    d.hold_a = wbyte;
                    if (!q.en_a) begin
                        d.cmp_a = wbyte;
                    end
                end
                ADDR_COMPARE_B: begin
                    d.hold_b = wbyte;
                    if (!q.en_b) begin
                        d.cmp_b = wbyte;
                    end
                end
                ADDR_PERIOD: begin
                    d.period = wbyte;
                end
                ADDR_PLL: begin
                    d.pll_en = wbyte[PLL_EN_BIT];
                    // Dropping the PLL in the same write must also drop the fast clock.
                    d.fast_en = wbyte[FAST_EN_BIT] && wbyte[PLL_EN_BIT] && q.pll_en;
                end
                ADDR_IRQ_EN: begin
                    d.irq_en = wbyte[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q <= STATE_RESET;
        end else begin
            q <= d;
        end
    end

    assign o_avs_readdata = q.rdata;
    assign o_pll_enable = q.pll_en;
    assign o_irq_request = q.irq;

    pwm_channel u_chan_a (
        .i_clk        (i_clk),
        .i_rst_n      (i_rst_n),
        .i_mode       (q.mode_a),
        .i_enable     (q.en_a),
        .i_count      (q.cnt),
        .i_compare    (q.cmp_a),
        .i_period     (q.period),
        .i_scaled_tick(tick),
        .i_base_tick  (base_tick),
        .o_true       (o_pwm_a_out),
        .o_inv        (o_pwm_a_inv),
        .o_true_drive (o_pwm_a_drive),
        .o_inv_drive  (o_pwm_a_inv_drive)
    );

    pwm_channel u_chan_b (
        .i_clk        (i_clk),
        .i_rst_n      (i_rst_n),
        .i_mode       (q.mode_b),
        .i_enable     (q.en_b),
        .i_count      (q.cnt),
        .i_compare    (q.cmp_b),
        .i_period     (q.period),
        .i_scaled_tick(tick),
        .i_base_tick  (base_tick),
        .o_true       (o_pwm_b_out),
        .o_inv        (o_pwm_b_inv),
        .o_true_drive (o_pwm_b_drive),
        .o_inv_drive  (o_pwm_b_inv_drive)
    );

    chk_count_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        tick && wrap && !wr |=> q.cnt == 8'h00) else $error("no wrap");
    chk_count_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        tick && !wrap && !wr |=> q.cnt == $past(q.cnt) + 8'h01) else $error("bad step");
    chk_hold_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        tick && wrap && q.en_a |=> q.cmp_a == $past(q.hold_a)) else $error("no load");
    chk_ovf_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        tick && wrap |-> ##2 q.flags[FLAG_OVF]) else $error("no ovf flag");
    chk_stop_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        q.select == 4'h0 && !wr |=> $stable(q.cnt)) else $error("counter ran");
    chk_read_back: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr && i_avs_address == ADDR_COMPARE_A |=> q.hold_a == $past(wbyte)) else $error("hold");
    chk_fast_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        q.fast_en |-> q.pll_en) else $error("fast w/o pll");
    chk_irq_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_irq_request |-> $past(i_global_irq_enable)) else $error("irq ungated");
    cov_wrap: cover property (@(posedge i_clk) disable iff (!i_rst_n) tick && wrap);
    cov_read: cover property (@(posedge i_clk) disable iff (!i_rst_n) q.bus == BUS_ANSWER);
    cov_irq: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_irq_request));
endmodule

//--- hw/pwm_pkg.sv
package pwm_pkg;

    // Register word indices; byte address is four times the index.
    localparam logic [3:0] ADDR_CONTROL_A = 4'h0;
    localparam logic [3:0] ADDR_CONTROL_B = 4'h1;
    localparam logic [3:0] ADDR_COUNTER   = 4'h2;
    localparam logic [3:0] ADDR_COMPARE_A = 4'h3;
    localparam logic [3:0] ADDR_COMPARE_B = 4'h4;
    localparam logic [3:0] ADDR_PERIOD    = 4'h5;
    localparam logic [3:0] ADDR_PLL       = 4'h6;
    localparam logic [3:0] ADDR_FLAGS     = 4'h7;
    localparam logic [3:0] ADDR_IRQ_EN    = 4'h8;

    // Field positions.
    localparam int MODE_A_LSB   = 6;
    localparam int MODE_B_LSB   = 4;
    localparam int PWM_A_EN_BIT = 1;
    localparam int PWM_B_EN_BIT = 0;
    localparam int PSR_BIT      = 6;
    localparam int FAST_EN_BIT  = 2;
    localparam int PLL_EN_BIT   = 1;
    localparam int LOCKED_BIT   = 0;
    localparam int FLAG_OVF     = 2;
    localparam int FLAG_CMP_A   = 1;
    localparam int FLAG_CMP_B   = 0;

    // Reset values.
    localparam logic [7:0] PERIOD_RESET  = 8'hff;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [3:0] SELECT_RESET  = 4'h0;

    typedef enum logic [1:0] {
        MODE_OFF  = 2'h0,
        MODE_PAIR = 2'h1,
        MODE_CLR  = 2'h2,
        MODE_SET  = 2'h3
    } mode_t;

    typedef enum logic {
        BUS_IDLE   = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_t;

    // Sticky flag update where a new event beats a clear in the same cycle.
    function automatic logic [2:0] flag_update(logic [2:0] q, logic [2:0] set, logic [2:0] clr);
        flag_update = (q & ~clr) | set;
    endfunction

endpackage

//--- hw/pwm_prescaler.sv
`timescale 1ns/1ps
module pwm_prescaler #(
    parameter int DIV_W = 14
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_base_tick,
    input  wire logic [3:0] i_select,
    input  wire logic       i_clear,
    output logic            o_tick
);
    import pwm_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] div;
    } state_t;

    state_t q;
    state_t d;
    logic [DIV_W-1:0] mask;

    // Codes above one pick a power-of-two tap of the free divider.
    always_comb begin
        d = q;
        mask = DIV_W'((DIV_W'(1) << (i_select - 4'h1)) - DIV_W'(1));
        if (i_clear) begin
            d.div = '0;
        end else if (i_base_tick) begin
            d.div = q.div + DIV_W'(1);
        end
        if (i_select == SELECT_RESET) begin
            o_tick = 1'b0;
        end else begin
            o_tick = i_base_tick & (&(q.div | ~mask));
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    chk_stop_no_tick: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_select == 4'h0 |-> !o_tick) else $error("tick while stopped");
    chk_div_one: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_select == 4'h1 |-> o_tick == i_base_tick) else $error("div1 wrong");
endmodule

//--- hw/pwm_channel.sv
`timescale 1ns/1ps
module pwm_channel (
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    input  pwm_pkg::mode_t     i_mode,
    input  wire logic          i_enable,
    input  wire logic [7:0]    i_count,
    input  wire logic [7:0]    i_compare,
    input  wire logic [7:0]    i_period,
    input  wire logic          i_scaled_tick,
    input  wire logic          i_base_tick,
    output logic               o_true,
    output logic               o_inv,
    output logic               o_true_drive,
    output logic               o_inv_drive
);
    import pwm_pkg::*;

    // Index 0 is the true output, index 1 the inverted one.
    typedef struct packed {
        logic [1:0] tgt;
        logic [1:0] wait_ps;
        logic [1:0] go;
        logic [1:0] out;
        logic       drv_t;
        logic       drv_i;
    } state_t;

    state_t q;
    state_t d;
    logic       ideal;
    logic [1:0] tgt;
    logic [1:0] slow;

    // Ideal waveform, with fixed levels at the two extreme compare values.
    always_comb begin
        if (i_compare == i_period) begin
            ideal = 1'b1;
        end else begin
            ideal = (i_count != 8'h00) && (i_count < i_compare);
        end
        tgt[0] = i_enable && (i_mode == MODE_SET ? !ideal : (i_mode != MODE_OFF && ideal));
        tgt[1] = i_enable && i_mode == MODE_PAIR && !ideal;
        slow[0] = i_mode != MODE_CLR;
        slow[1] = 1'b1;
    end

    // Rising edges wait a prescaled tick then a base tick, except the true output in mode 10, which waits a base tick only; falling edges a base tick only.
    // That skew is the dead time, so the pair can never be high together.
    always_comb begin
        d = q;
        d.tgt = tgt;
        d.drv_t = i_enable && i_mode != MODE_OFF;
        d.drv_i = i_enable && i_mode == MODE_PAIR;
        for (int k = 0; k < 2; k++) begin
            if (!tgt[k]) begin
                d.wait_ps[k] = 1'b0;
                d.go[k] = 1'b0;
                if (i_base_tick) begin
                    d.out[k] = 1'b0;
                end
            end else begin
                if (!q.tgt[k]) begin
                    d.wait_ps[k] = slow[k];
                    d.go[k] = !slow[k];
                end else if (q.wait_ps[k] && i_scaled_tick) begin
                    d.wait_ps[k] = 1'b0;
                    d.go[k] = 1'b1;
                end
                if (q.go[k] && i_base_tick) begin
                    d.out[k] = 1'b1;
                    d.go[k] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_true = q.out[0];
    assign o_inv = q.out[1];
    assign o_true_drive = q.drv_t;
    assign o_inv_drive = q.drv_i;

    chk_no_overlap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(o_true && o_inv)) else $error("pair overlaps");
    chk_fall_one_tick: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !tgt[0] && i_base_tick |=> !o_true) else $error("late fall");
    chk_rise_after_go: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_true) |-> $past(q.go[0]) && $past(i_base_tick)) else $error("early rise");
    chk_inv_detached: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_mode != MODE_PAIR |=> !o_inv_drive) else $error("inv driven");
    cov_pair_toggle: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_mode == MODE_PAIR && $rose(o_inv));
endmodule

//--- tb/power_stage_model.sv
`timescale 1ns/1ps
// Gate drivers of two half bridges; an undriven pin is pulled down.
module power_stage_model (
    input  wire logic       i_clk,
    input  wire logic       i_a_true,
    input  wire logic       i_a_inv,
    input  wire logic       i_a_drive,
    input  wire logic       i_a_inv_drive,
    input  wire logic       i_b_true,
    input  wire logic       i_b_inv,
    input  wire logic       i_b_drive,
    input  wire logic       i_b_inv_drive,
    output logic            o_pin_a,
    output logic            o_pin_b,
    output logic [7:0]      o_overlap
);
    logic pin_a_inv;
    logic pin_b_inv;

    // Pull-downs hold a released pin low, so a floating gate never turns a switch on.
    assign o_pin_a   = i_a_drive ? i_a_true : 1'b0;
    assign pin_a_inv = i_a_inv_drive ? i_a_inv : 1'b0;
    assign o_pin_b   = i_b_drive ? i_b_true : 1'b0;
    assign pin_b_inv = i_b_inv_drive ? i_b_inv : 1'b0;

    // Both switches of one leg on at once is a shoot-through, counted here.
    initial o_overlap = 8'h00;
    always @(posedge i_clk) begin
        if ((o_pin_a && pin_a_inv) || (o_pin_b && pin_b_inv)) begin
            o_overlap <= o_overlap + 8'h01;
        end
    end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import pwm_pkg::*;
    logic        i_clk   = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [3:0]  adr     = 4'h0;
    logic        rd      = 1'b0;
    logic        wr      = 1'b0;
    logic [31:0] wdat    = 32'h0;
    logic [3:0]  be      = 4'h1;
    logic        fclk    = 1'b0;
    logic [1:0]  fdiv    = 2'h0;
    logic        lock    = 1'b0;
    logic        gie     = 1'b0;
    logic [31:0] rdat;
    logic        wreq, pll_en, irq, a_t, a_i, a_d, a_id, b_t, b_i, b_d, b_id, pin_a, pin_b;
    logic [7:0]  ovl, v;
    int          err_count = 0;
    int          n_tests   = 0;
    int          gap;

    always #12.5 i_clk = ~i_clk;

    // Fast clock at a quarter of the system rate, kept below half of it.
    always @(posedge i_clk) begin
        fdiv <= fdiv + 2'h1;
        fclk <= fdiv[1];
    end

    pwm_timer dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .i_fast_pll_clock(fclk), .i_pll_locked(lock),
        .i_global_irq_enable(gie), .o_pll_enable(pll_en), .o_irq_request(irq),
        .o_pwm_a_out(a_t), .o_pwm_a_inv(a_i), .o_pwm_a_drive(a_d), .o_pwm_a_inv_drive(a_id),
        .o_pwm_b_out(b_t), .o_pwm_b_inv(b_i), .o_pwm_b_drive(b_d), .o_pwm_b_inv_drive(b_id));

    power_stage_model sw_u (.i_clk(i_clk), .i_a_true(a_t), .i_a_inv(a_i), .i_a_drive(a_d),
        .i_a_inv_drive(a_id), .i_b_true(b_t), .i_b_inv(b_i), .i_b_drive(b_d),
        .i_b_inv_drive(b_id), .o_pin_a(pin_a), .o_pin_b(pin_b), .o_overlap(ovl));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Each access holds its request until waitrequest is seen low, then idles one cycle.
    task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
        adr  <= a;
        wdat <= {24'h0, d};
        wr   <= 1'b1;
        @(posedge i_clk);
        while (wreq !== 1'b0) @(posedge i_clk);
        wr <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
        adr <= a;
        rd  <= 1'b1;
        @(posedge i_clk);
        while (wreq !== 1'b0) @(posedge i_clk);
        d  = rdat[7:0];
        rd <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bus_read(a, d);
        check(d, exp);
    endtask

    // Cycles between two rising edges on the true pin of channel A.
    task automatic rise_gap(output int g);
        int   n;
        logic p;
        n = 0;
        g = 0;
        p = pin_a;
        while (n < 2 && g < 4000) begin
            @(posedge i_clk);
            g++;
            if (pin_a === 1'b1 && p !== 1'b1) begin
                n++;
                if (n == 1) g = 0;
            end
            p = pin_a;
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under ten thousand cycles.
    initial begin
        repeat (40000) @(posedge i_clk);
        err_count++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        rd_check(ADDR_PERIOD, PERIOD_RESET);
        rd_check(ADDR_COMPARE_A, COMPARE_RESET);
        rd_check(ADDR_COMPARE_B, COMPARE_RESET);
        rd_check(ADDR_CONTROL_B, {4'h0, SELECT_RESET});
        rd_check(ADDR_PLL, 8'h00);
        bus_write(4'h9, 8'h5a);
        rd_check(4'h9, 8'h00);
        be <= 4'h0;
        bus_write(ADDR_PERIOD, 8'h10);
        be <= 4'h1;
        rd_check(ADDR_PERIOD, PERIOD_RESET);
        $display("Test registers done");

        // Period three, divide by one, channel B runs a complementary pair throughout.
        bus_write(ADDR_PERIOD, 8'h03);
        bus_write(ADDR_COMPARE_B, 8'h02);
        bus_write(ADDR_CONTROL_B, 8'h01);
        for (int m = 0; m < 4; m++) begin
            bus_write(ADDR_CONTROL_A, {m[1:0], 6'h13});
            repeat (3) @(posedge i_clk);
            check({7'h0, a_d}, {7'h0, m != 0});
            check({7'h0, a_id}, {7'h0, m == 1});
            check({7'h0, b_id}, 8'h01);
        end
        $display("Test modes done");

        for (int m = 1; m < 4; m++) begin
            for (int c = 0; c < 2; c++) begin
                bus_write(ADDR_CONTROL_A, {m[1:0], 6'h13});
                bus_write(ADDR_COMPARE_A, c ? 8'h03 : 8'h00);
                repeat (20) @(posedge i_clk);
                check({7'h0, pin_a}, {7'h0, (m == 3) ? c == 0 : c == 1});
                if (m == 1) check({7'h0, a_i}, {7'h0, c == 0});
                repeat (5) @(posedge i_clk);
                check({7'h0, pin_a}, {7'h0, (m == 3) ? c == 0 : c == 1});
            end
        end
        $display("Test static levels done");

        // Period seven leaves room for a true pulse after the one-tick dead time.
        bus_write(ADDR_PERIOD, 8'h07);
        bus_write(ADDR_CONTROL_A, 8'h53);
        bus_write(ADDR_COMPARE_A, 8'h04);
        for (int s = 1; s < 6; s++) begin
            bus_write(ADDR_CONTROL_B, s[7:0]);
            rise_gap(gap);
            rise_gap(gap);
            check(gap[7:0], 8'h08 << (s - 1));
        end
        for (int m = 2; m < 4; m++) begin
            bus_write(ADDR_CONTROL_B, 8'h01);
            bus_write(ADDR_CONTROL_A, {m[1:0], 6'h13});
            rise_gap(gap);
            check(gap[7:0], 8'h08);
        end
        check(ovl, 8'h00);
        $display("Test period done");

        // A compare written while stopped is read back but not yet used.
        bus_write(ADDR_CONTROL_A, 8'h53);
        bus_write(ADDR_COMPARE_A, 8'h00);
        repeat (20) @(posedge i_clk);
        bus_write(ADDR_CONTROL_B, 8'h00);
        bus_write(ADDR_COMPARE_A, 8'h07);
        rd_check(ADDR_COMPARE_A, 8'h07);
        repeat (20) @(posedge i_clk);
        check({7'h0, pin_a}, 8'h00);
        bus_write(ADDR_CONTROL_B, 8'h01);
        repeat (20) @(posedge i_clk);
        check({7'h0, pin_a}, 8'h01);
        $display("Test compare hold done");

        for (int i = 0; i < 8; i++) begin
            bus_read(ADDR_COUNTER, v);
            check({7'h0, v <= 8'h07}, 8'h01);
        end
        bus_write(ADDR_IRQ_EN, 8'h04);
        gie <= 1'b1;
        repeat (10) @(posedge i_clk);
        bus_read(ADDR_FLAGS, v);
        check({7'h0, v[FLAG_OVF]}, 8'h01);
        check({7'h0, irq}, 8'h01);
        bus_write(ADDR_CONTROL_B, 8'h00);
        bus_write(ADDR_FLAGS, 8'h07);
        repeat (3) @(posedge i_clk);
        rd_check(ADDR_FLAGS, 8'h00);
        check({7'h0, irq}, 8'h00);
        bus_write(ADDR_COUNTER, 8'h05);
        repeat (10) @(posedge i_clk);
        rd_check(ADDR_COUNTER, 8'h05);
        rd_check(ADDR_COUNTER, 8'h05);
        $display("Test flags and stop done");

        // Fast clock only after the PLL is enabled in an earlier write; lock is not required.
        bus_write(ADDR_PLL, 8'h04);
        rd_check(ADDR_PLL, 8'h00);
        bus_write(ADDR_PLL, 8'h02);
        repeat (2) @(posedge i_clk);
        check({7'h0, pll_en}, 8'h01);
        lock <= 1'b1;
        rd_check(ADDR_PLL, 8'h03);
        bus_write(ADDR_PLL, 8'h06);
        rd_check(ADDR_PLL, 8'h07);
        for (int s = 1; s < 3; s++) begin
            bus_write(ADDR_CONTROL_A, 8'h53);
            bus_write(ADDR_COMPARE_A, 8'h04);
            bus_write(ADDR_CONTROL_B, s[7:0]);
            rise_gap(gap);
            rise_gap(gap);
            check(gap[7:0], 8'h20 << (s - 1));
        end
        check(ovl, 8'h00);
        $display("Test fast clock done");
        end_of_test();
    end
endmodule
